// ===== src/fpbs_defs.vh
// Purpose: constants for the fan drive behaviour select block
// Assumes: AHB-Lite word registers, byte address = 4 * register index
// Notes: offsets remote1_range_freq and remote2_range_freq are not multiples of four, so they are indices
`ifndef FPBS_DEFS_VH
`define FPBS_DEFS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FPBS_IDX_DUTY1 8'h30
`define FPBS_IDX_DUTY2 8'h31
`define FPBS_IDX_DUTY3 8'h32
`define FPBS_IDX_SUBST 8'h36
`define FPBS_IDX_CFG1 8'h40
`define FPBS_IDX_REM1_RF 8'h5f
`define FPBS_IDX_LOC_RF 8'h60
`define FPBS_IDX_REM2_RF 8'h61
`define FPBS_IDX_BHV1 8'h5c
`define FPBS_IDX_BHV2 8'h5d
`define FPBS_IDX_BHV3 8'h5e
`define FPBS_IDX_STATUS 8'h70

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FPBS_BIT_ENCSET 3
`define FPBS_BIT_FLIP 4
`define FPBS_BHV_HI 7
`define FPBS_BHV_LO 5
`define FPBS_BIT_LOCK 1
`define FPBS_BIT_SUBST 4
`define FPBS_RF_RESET 8'hc4
`define FPBS_BHV_RESET 8'h62
`define FPBS_DUTY_RESET 8'hff
`define FPBS_DUTY_FULL 8'hff
`define FPBS_DUTY_ZERO 8'h00

// ----------------------------------------
// behaviour codes
// ----------------------------------------
`define FPBS_B_000 3'h0
`define FPBS_B_001 3'h1
`define FPBS_B_010 3'h2
`define FPBS_B_011 3'h3
`define FPBS_B_100 3'h4
`define FPBS_B_101 3'h5
`define FPBS_B_110 3'h6
`define FPBS_B_111 3'h7

`endif

// ===== src/fpbs_top.v
// Purpose: behaviour select, duty pick and PWM output for three fan drive channels
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: temperature-to-duty conversion is outside; duties arrive as 8-bit inputs
//
// How it works
// - polarity flip clear drives pin high during the active part of the period
// - polarity flip set inverts the pin, full duty gives a constant low
// - default set code 000 takes duty from first remote temperature
// - default set code 001 takes duty from local temperature
// - default set code 010 takes duty from second remote temperature
// - default set code 011 runs full speed, and it is the reset code
// - default set code 100 disables the channel drive
// - default set code 101 drives larger of local and second remote duty
// - default set code 110 drives highest of local and both remote duties
// - default set code 111 is manual, duty registers become writable
// - alternative set codes 000 to 011 pick platform thermal inputs 0 to 3
// - alternative set codes 100 and 110 run the channel at full duty
// - alternative set code 101 drives highest of four platform input duties
// - alternative set code 111 drives highest duty across every thermal zone
// - lock bit makes behaviour and range/frequency registers ignore writes
// - substitution bit forces channel 1 onto the alternative encoding set
// - three range/frequency registers reset to 0xc4
// - behaviour register bit 3 selects the alternative encoding set, reset 0
//
// Register access over AHB-Lite was left to the implementer.
`include "fpbs_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module fpbs_top #(
   parameter PERIOD_STEPS = 255
) (
   input wire clk_sys,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire [7:0] duty_remote1,
   input wire [7:0] duty_local,
   input wire [7:0] duty_remote2,
   input wire [7:0] platform_thermal_input_0,
   input wire [7:0] platform_thermal_input_1,
   input wire [7:0] platform_thermal_input_2,
   input wire [7:0] platform_thermal_input_3,
   output reg [2:0] fan_drive_channel
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [7:0] max2;
      input [7:0] a;
      input [7:0] b;
      begin
         max2 = (a > b) ? a : b;
      end
   endfunction

   // picks the duty for one channel; bit 8 of the result marks disabled
   function [8:0] pick_duty;
      input second_set;
      input [2:0] code;
      input [7:0] man;
      input [7:0] r1;
      input [7:0] lc;
      input [7:0] r2;
      input [7:0] p0;
      input [7:0] p1;
      input [7:0] p2;
      input [7:0] p3;
      reg [7:0] pmax;
      begin
         pmax = max2(max2(p0, p1), max2(p2, p3));
         pick_duty = {1'b0, `FPBS_DUTY_FULL};
         if (second_set) begin
            case (code)
               `FPBS_B_000: pick_duty = {1'b0, p0};
               `FPBS_B_001: pick_duty = {1'b0, p1};
               `FPBS_B_010: pick_duty = {1'b0, p2};
               `FPBS_B_011: pick_duty = {1'b0, p3};
               `FPBS_B_101: pick_duty = {1'b0, pmax};
               `FPBS_B_111: pick_duty = {1'b0, max2(pmax, max2(r1, max2(lc, r2)))};
               default: pick_duty = {1'b0, `FPBS_DUTY_FULL};
            endcase
         end else begin
            case (code)
               `FPBS_B_000: pick_duty = {1'b0, r1};
               `FPBS_B_001: pick_duty = {1'b0, lc};
               `FPBS_B_010: pick_duty = {1'b0, r2};
               `FPBS_B_011: pick_duty = {1'b0, `FPBS_DUTY_FULL};
               `FPBS_B_100: pick_duty = {1'b1, `FPBS_DUTY_ZERO};
               `FPBS_B_101: pick_duty = {1'b0, max2(lc, r2)};
               `FPBS_B_110: pick_duty = {1'b0, max2(r1, max2(lc, r2))};
               default: pick_duty = {1'b0, man};
            endcase
         end
      end
   endfunction

   // channel 0..2 of an index inside a trio of registers that starts at base
   function [1:0] chan_of;
      input [7:0] idx;
      input [7:0] base;
      reg [7:0] diff;
      begin
         diff = idx - base;
         chan_of = diff[1:0];
      end
   endfunction

   // manual duty exists only in the default set, so a forced second set refuses it
   function is_manual;
      input second_set;
      input [2:0] code;
      begin
         is_manual = !second_set && (code == `FPBS_B_111);
      end
   endfunction

   // level of one pin; full scale is a constant active level, a disabled channel sits idle
   function pin_level;
      input off;
      input [7:0] duty;
      input [7:0] cnt;
      input flip;
      begin
         if (off) begin
            pin_level = flip;
         end else begin
            pin_level = ((duty == `FPBS_DUTY_FULL) || (cnt < duty)) ^ flip;
         end
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] bhv [0:2];
   reg [7:0] rng [0:2];
   reg [7:0] duty_man [0:2];
   reg [7:0] subst;
   reg [7:0] cfg1;
   reg [7:0] pwm_cnt;
   reg [7:0] duty_now [0:2];
   reg [2:0] disabled;

   reg dp_write;
   reg dp_read;
   reg [7:0] dp_idx;
   reg [31:0] rdata;
   wire [2:0] eff_set;

   wire lock = cfg1[`FPBS_BIT_LOCK];
   wire subst_on = subst[`FPBS_BIT_SUBST];
   wire take = hsel & hready & htrans[1];
   wire [7:0] a_idx = haddr[9:2];
   wire [7:0] wbyte = hwdata[7:0];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata;

   // ----------------------------------------
   // bus slave: address phase latched, write done in data phase
   // ----------------------------------------
   integer i;
   integer j;
   integer k;
   always @(posedge clk_sys) begin
      if (!resetn) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_idx <= 8'h00;
      end else begin
         dp_write <= take & hwrite;
         dp_read <= take & ~hwrite;
         dp_idx <= a_idx;
      end
   end

   always @(posedge clk_sys) begin
      if (!resetn) begin
         for (i = 0; i < 3; i = i + 1) begin
            bhv[i] <= `FPBS_BHV_RESET;
            rng[i] <= `FPBS_RF_RESET;
            duty_man[i] <= `FPBS_DUTY_RESET;
         end
         subst <= 8'h00;
         cfg1 <= 8'h00;
      end else if (dp_write) begin
         case (dp_idx)
            `FPBS_IDX_BHV1, `FPBS_IDX_BHV2, `FPBS_IDX_BHV3: begin
               if (!lock) begin
                  bhv[chan_of(dp_idx, `FPBS_IDX_BHV1)] <= wbyte;
               end
            end
            `FPBS_IDX_REM1_RF, `FPBS_IDX_LOC_RF, `FPBS_IDX_REM2_RF: begin
               if (!lock) begin
                  rng[chan_of(dp_idx, `FPBS_IDX_REM1_RF)] <= wbyte;
               end
            end
            `FPBS_IDX_DUTY1, `FPBS_IDX_DUTY2, `FPBS_IDX_DUTY3: begin
               // writable only while that channel is in manual mode
               if (is_manual(eff_set[chan_of(dp_idx, `FPBS_IDX_DUTY1)],
                             bhv[chan_of(dp_idx, `FPBS_IDX_DUTY1)][`FPBS_BHV_HI:`FPBS_BHV_LO])) begin
                  duty_man[chan_of(dp_idx, `FPBS_IDX_DUTY1)] <= wbyte;
               end
            end
            `FPBS_IDX_SUBST: begin
               subst <= wbyte;
            end
            `FPBS_IDX_CFG1: begin
               // lock is sticky until reset
               cfg1 <= wbyte | (cfg1 & 8'h02);
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // effective encoding set per channel
   // ----------------------------------------
   assign eff_set[0] = bhv[0][`FPBS_BIT_ENCSET] | subst_on;
   assign eff_set[1] = bhv[1][`FPBS_BIT_ENCSET];
   assign eff_set[2] = bhv[2][`FPBS_BIT_ENCSET];

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [7:0] rbyte;
   always @* begin
      rbyte = 8'h00;
      case (dp_idx)
         `FPBS_IDX_BHV1: rbyte = bhv[0];
         `FPBS_IDX_BHV2: rbyte = bhv[1];
         `FPBS_IDX_BHV3: rbyte = bhv[2];
         `FPBS_IDX_REM1_RF: rbyte = rng[0];
         `FPBS_IDX_LOC_RF: rbyte = rng[1];
         `FPBS_IDX_REM2_RF: rbyte = rng[2];
         `FPBS_IDX_DUTY1: rbyte = duty_now[0];
         `FPBS_IDX_DUTY2: rbyte = duty_now[1];
         `FPBS_IDX_DUTY3: rbyte = duty_now[2];
         `FPBS_IDX_SUBST: rbyte = subst;
         `FPBS_IDX_CFG1: rbyte = cfg1;
         `FPBS_IDX_STATUS: rbyte = {2'h0, eff_set, disabled};
         default: rbyte = 8'h00;
      endcase
   end

   // data phase is combinational from the latched index, zero wait
   always @* begin
      rdata = 32'h00000000;
      if (dp_read) begin
         rdata = {24'h000000, rbyte};
      end
   end

   // ----------------------------------------
   // duty selection and pwm
   // ----------------------------------------
   reg [8:0] sel [0:2];
   always @* begin
      for (j = 0; j < 3; j = j + 1) begin
         sel[j] = pick_duty(eff_set[j], bhv[j][`FPBS_BHV_HI:`FPBS_BHV_LO], duty_man[j],
                            duty_remote1, duty_local, duty_remote2,
                            platform_thermal_input_0, platform_thermal_input_1,
                            platform_thermal_input_2, platform_thermal_input_3);
      end
   end

   localparam [31:0] LAST_FULL = PERIOD_STEPS - 1;
   localparam [7:0] LAST_STEP = LAST_FULL[7:0];

   // the counter wraps at the period end so every duty below full scale repeats
   wire [7:0] next_cnt = (pwm_cnt == LAST_STEP) ? 8'h00 : pwm_cnt + 8'h01;

   always @(posedge clk_sys) begin
      if (!resetn) begin
         pwm_cnt <= 8'h00;
         disabled <= 3'h0;
         fan_drive_channel <= 3'h7;
         for (k = 0; k < 3; k = k + 1) begin
            duty_now[k] <= `FPBS_DUTY_FULL;
         end
      end else begin
         pwm_cnt <= next_cnt;
         for (k = 0; k < 3; k = k + 1) begin
            duty_now[k] <= sel[k][7:0];
            disabled[k] <= sel[k][8];
            fan_drive_channel[k] <= pin_level(sel[k][8], sel[k][7:0], pwm_cnt,
                                              bhv[k][`FPBS_BIT_FLIP]);
         end
      end
   end

endmodule

`default_nettype wire

// ===== dv/fpbs_fan_model.sv
// Purpose: fan stand-in that counts clocks with its drive pin high
// Assumes: pin sampled on the system clock
// Notes: only a clean high counts, so an unknown pin never looks energised
`timescale 1ns/1ns
`default_nettype none
module fpbs_fan_model (
   input wire logic clk_sys,
   input wire logic pin,
   input wire logic clr,
   output logic [7:0] on_cycles
);
   always @(posedge clk_sys) begin
      if (clr) begin
         on_cycles <= 8'h00;
      end else if (pin === 1'b1) begin
         on_cycles <= on_cycles + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== dv/fpbs_chk.sv
// Purpose: port checker for fpbs_top
// Assumes: zero wait bus slave, data phase one cycle after the address
// Notes: bound to every fpbs_top
`timescale 1ns/1ns
`default_nettype none
module fpbs_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [2:0] fan_drive_channel
);
   // ----------------
   // read phase track
   // ----------------
   logic rd_ph, wr_ph, lock_seen;
   logic [7:0] rd_idx;
   always @(posedge clk_sys) begin
      if (!resetn) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
         lock_seen <= 1'b0;
         rd_idx <= 8'h00;
      end else begin
         rd_ph <= hsel & hready & htrans[1] & !hwrite;
         wr_ph <= hsel & hready & htrans[1] & hwrite;
         // only a reset may take the lock away once software has set it
         lock_seen <= lock_seen | (wr_ph & (rd_idx == 8'h40) & hwdata[1]);
         rd_idx <= haddr[9:2];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not okay");
   release_pins_a: assert property ($rose(resetn) |->
      fan_drive_channel == 3'h7 ##1 fan_drive_channel == 3'h7) else $error("pins not full");
   idle_data_a: assert property (!rd_ph |-> hrdata == 32'h0) else $error("stray read data");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
   no_select_a: assert property (!hsel |=> hrdata == 32'h0) else $error("data unselected");
   unmapped_read_a: assert property (rd_ph && rd_idx == 8'h00 |-> hrdata == 32'h0)
      else $error("unmapped read");
   lock_sticky_a: assert property (rd_ph && rd_idx == 8'h40 && lock_seen |-> hrdata[1])
      else $error("lock bit cleared");
   cover property (rd_ph);
   cover property (rd_ph && rd_idx == 8'h5f);
   cover property (fan_drive_channel == 3'h0);
endmodule
bind fpbs_top fpbs_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .fan_drive_channel(fan_drive_channel));
`default_nettype wire

// ===== dv/fan_pwm_behaviour_select_tb.sv
// Purpose: self-checking bench for fpbs_top
// Assumes: PERIOD_STEPS cut to 16, so a duty below 16 gives that many high clocks
// Notes: duty is measured on channel 1 only, to keep the bench short
`timescale 1ns/1ns
`default_nettype none
module fan_pwm_behaviour_select_tb;
   logic clk_sys, resetn, hsel, hwrite, clr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, q;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp;
   wire logic [2:0] pins;
   wire logic [7:0] on_cycles;
   logic [7:0] r1, lc, r2, p0, p1, p2, p3;
   int fails, check_count;
   // row: {second encoding set, code, expected high clocks}
   logic [11:0] rows [16] = '{12'h00d, 12'h108, 12'h20b, 12'h310, 12'h400, 12'h50b,
      12'h60d, 12'h710, 12'h802, 12'h906, 12'ha09, 12'hb05, 12'hc10, 12'hd09, 12'he10, 12'hf0d};
   fpbs_top #(.PERIOD_STEPS(16)) DUT (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .duty_remote1(r1), .duty_local(lc), .duty_remote2(r2), .platform_thermal_input_0(p0),
      .platform_thermal_input_1(p1), .platform_thermal_input_2(p2),
      .platform_thermal_input_3(p3), .fan_drive_channel(pins));
   fpbs_fan_model fan (.clk_sys(clk_sys), .pin(pins[0]), .clr(clr), .on_cycles(on_cycles));
   // ----------------
   // tasks
   // ----------------
   task report_and_stop;
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task ahb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // measuring a whole period makes the count independent of counter phase
   task measure(input logic [31:0] exp);
      repeat (4) @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 check({24'h0, on_cycles}, exp);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      report_and_stop;
   end
   initial begin
      {resetn, hsel, hwrite, clr, htrans, hsize, haddr, hwdata} = '0;
      {r1, lc, r2} = {8'h0d, 8'h08, 8'h0b};
      {p0, p1, p2, p3} = {8'h02, 8'h06, 8'h09, 8'h05};
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         ahb(1'b0, 8'h5f + 8'(i), 32'h0);
         check(q, 32'hc4);
      end
      ahb(1'b0, 8'h5c, 32'h0);
      check(q, 32'h62);
      for (int i = 0; i < 16; i++) begin
         ahb(1'b1, 8'h5c, {24'h0, rows[i][10:8], 1'b0, rows[i][11], 3'b010});
         measure({24'h0, rows[i][7:0]});
      end
      ahb(1'b1, 8'h5c, 32'h72);
      measure(32'h0);
      ahb(1'b1, 8'h5c, 32'h92);
      measure(32'h10);
      ahb(1'b1, 8'h5c, 32'h82);
      measure(32'h0);
      ahb(1'b1, 8'h5c, 32'he2);
      ahb(1'b1, 8'h30, 32'h03);
      measure(32'h03);
      ahb(1'b1, 8'h36, 32'h10);
      ahb(1'b1, 8'h5c, 32'h02);
      measure(32'h02);
      ahb(1'b1, 8'h40, 32'h02);
      ahb(1'b1, 8'h5f, 32'h11);
      ahb(1'b0, 8'h5f, 32'h0);
      check(q, 32'hc4);
      ahb(1'b1, 8'h5c, 32'h62);
      ahb(1'b0, 8'h5c, 32'h0);
      check(q, 32'h02);
      ahb(1'b1, 8'h40, 32'h00);
      ahb(1'b0, 8'h40, 32'h0);
      check(q, 32'h02);
      ahb(1'b0, 8'h70, 32'h0);
      check(q, 32'h08);
      // second reset in mid-run clears the lock and restores full speed
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      ahb(1'b0, 8'h40, 32'h0);
      check(q, 32'h0);
      ahb(1'b1, 8'h5f, 32'h11);
      ahb(1'b0, 8'h5f, 32'h0);
      check(q, 32'h11);
      measure(32'h10);
      check({30'h0, pins[2:1]}, 32'h3);
      ahb(1'b0, 8'h00, 32'h0);
      check(q, 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
